// File: pkg/tte_pkg.sv
//==============================================================
// Thermal trip event status constants
//==============================================================
// Behaviour
// - Status bits show which thermal condition raised the error or interrupt.
// - A status bit clears only on a written one; otherwise it holds.
// - Catastrophic threshold falling through trip point sets status bit 9.
// - Hot threshold falling through trip point sets status bit 8.
// - Auxiliary threshold falling through trip point sets status bit 7.
// - Catastrophic threshold rising through trip point sets status bit 4.
// - Hot threshold rising through trip point sets status bit 3.
// - Auxiliary threshold rising through trip point sets status bit 2.
// - Reset returns status and SMI select registers to zero.
// - SMI select bit 2 lets a catastrophic trip send an SMI message.
// - SMI select bit 1 lets a hot trip send an SMI message.
// - SMI select bit 0 lets an auxiliary trip send an SMI message.
// - Per-threshold SMI selects act only with the global SMI enable.
package tte_pkg;

   // Bus geometry; printed offsets are register indices, byte address is index times four.
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned IDX_SHIFT   = 2;
   localparam logic [11:0] STATUS_IDX  = 12'hcea;
   localparam logic [11:0] SMI_SEL_IDX = 12'hcf1;
   localparam logic [11:0] IRQ_ST_IDX  = 12'hcf8;
   localparam logic [11:0] IRQ_MSK_IDX = 12'hcf9;
   localparam logic [11:0] CTRL_IDX    = 12'hcfa;

   // Threshold indices, matching the SMI select bit positions.
   localparam int unsigned THR_N   = 3;
   localparam int unsigned THR_AUX = 0;
   localparam int unsigned THR_HOT = 1;
   localparam int unsigned THR_CAT = 2;

   // Status bit of each threshold's rising and falling trip, indexed by threshold.
   localparam int unsigned RISE_POS [THR_N] = '{2, 3, 4};
   localparam int unsigned FALL_POS [THR_N] = '{7, 8, 9};

   // Register widths, implemented bits and reset values.
   localparam int unsigned STATUS_W    = 16;
   localparam logic [15:0] STATUS_IMPL = 16'h039c;
   localparam logic [15:0] STATUS_RST  = 16'h0000;
   localparam logic [7:0]  SMI_IMPL    = 8'h07;
   localparam logic [7:0]  SMI_RST     = 8'h00;
   localparam logic [15:0] MASK_RST    = 16'h0000;
   localparam int unsigned CTRL_GSMI   = 0;

endpackage

// File: design/tte_trip_edge.sv
//==============================================================
// Trip edge detector
//==============================================================
module tte_trip_edge #(
   parameter int unsigned N = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] level,
   output logic      [N-1:0] rise,
   output logic      [N-1:0] fall
);
   import tte_pkg::*;

   typedef struct packed {
      logic [N-1:0] prev;
   } tte_edge_s;

   tte_edge_s st;
   tte_edge_s next_st;

   // Remembers the last comparator level of each threshold.
   always_comb begin
      next_st      = st;
      next_st.prev = level;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // A change of level against the stored one is a trip through the point.
   assign rise = level & ~st.prev;
   assign fall = st.prev & ~level;
endmodule

// File: design/tte_sticky_bank.sv
//==============================================================
// Sticky flag bank
//==============================================================
module tte_sticky_bank #(
   parameter int unsigned      W    = 16,
   parameter logic [W-1:0]     IMPL = '1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);
   import tte_pkg::*;

   typedef struct packed {
      logic [W-1:0] flag;
   } tte_sticky_s;

   tte_sticky_s st;
   tte_sticky_s next_st;

   // A set in the clearing cycle wins; bits outside IMPL never hold a one.
   always_comb begin
      next_st      = st;
      next_st.flag = (set | (st.flag & ~clr)) & IMPL;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.flag;
endmodule

// File: design/tte_thermal_trip_event_status.sv
//==============================================================
// Thermal trip event status and SMI gating
//==============================================================
//
// Chosen here: register access over APB.
module tte_thermal_trip_event_status (
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   input  wire logic [tte_pkg::ADDR_W-1:0] paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      cat_trip,
   input  wire logic                      hot_trip,
   input  wire logic                      aux_trip,
   output logic                           smi_req,
   output logic      [2:0]                smi_source,
   output logic                           irq
);
   import tte_pkg::*;

   // Main registered state: bus-side registers, the read capture and the SMI pulse.
   typedef struct packed {
      logic [7:0]  smi_sel;
      logic        glob_smi;
      logic [15:0] irq_mask;
      logic [31:0] rdata;
      logic        smi_req;
      logic [2:0]  smi_src;
   } tte_main_s;

   tte_main_s st;
   tte_main_s next_st;

   // Reset copy, trip events, flag banks and bus decode.
   logic              rst_meta;
   logic              rst_n;
   logic [THR_N-1:0]  trip_lvl;
   logic [THR_N-1:0]  rise;
   logic [THR_N-1:0]  fall;
   logic [THR_N-1:0]  smi_gate;
   logic [THR_N-1:0]  smi_fire;
   logic [15:0]       status;
   logic [15:0]       status_set;
   logic [15:0]       status_clr;
   logic [15:0]       irq_stat;
   logic [15:0]       irq_clr;
   logic [31:0]       wmask;
   logic [31:0]       rd_val;
   logic              hit_status;
   logic              hit_sel;
   logic              hit_ist;
   logic              hit_msk;
   logic              hit_ctrl;
   logic              hit_any;
   logic              wr_acc;
   logic              rd_acc;

   //==============================================================
   // Helpers
   //==============================================================
   // True when the bus address is the byte address of a register index.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
      reg_hit = (a == ADDR_W'(32'(idx) << IDX_SHIFT));
   endfunction

   // Keeps old bits where the mask is low and takes new ones where it is high.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [15:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   //==============================================================
   // Reset release
   //==============================================================
   // Releases the reset through two flip-flops; only the second is used.
   // Assertion reaches every flop at once; only the release waits for the clock.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   //==============================================================
   // Trip detection and status
   //==============================================================
   // Comparator levels gathered in select-bit order.
   assign trip_lvl[THR_CAT] = cat_trip;
   assign trip_lvl[THR_HOT] = hot_trip;
   assign trip_lvl[THR_AUX] = aux_trip;

   tte_trip_edge #(
      .N (THR_N)
   ) u_edge (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .level (trip_lvl),
      .rise  (rise),
      .fall  (fall)
   );

   // cause identification: each threshold edge maps to its own status bit.
   always_comb begin
      status_set = '0;
      for (int t = 0; t < THR_N; t++) begin
         status_set[RISE_POS[t]] = rise[t];
         status_set[FALL_POS[t]] = fall[t];
      end
   end

   // A clear and a set in one cycle leave the bit set, so no event is lost.
   // write-one clear: only written ones in enabled lanes clear status.
   assign status_clr = (wr_acc && hit_status) ? (pwdata[15:0] & wmask[15:0]) : '0;

   // reserved bits: IMPL keeps them zero whatever is written.
   tte_sticky_bank #(
      .W    (STATUS_W),
      .IMPL (STATUS_IMPL)
   ) u_status (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .set   (status_set),
      .clr   (status_clr),
      .q     (status)
   );

   // Interrupt copy of the events; a read clears only the bits it returned.
   assign irq_clr = (rd_acc && hit_ist) ? st.rdata[15:0] : '0;

   tte_sticky_bank #(
      .W    (STATUS_W),
      .IMPL (STATUS_IMPL)
   ) u_irq (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .set   (status_set),
      .clr   (irq_clr),
      .q     (irq_stat)
   );

   // Level interrupt: high while any event bit stands whose irq_mask bit is set.
   assign irq = |(irq_stat & st.irq_mask);

   //==============================================================
   // SMI message gating
   //==============================================================
   // A trip in either direction of a selected threshold sends one message,
   // registered so that the request and its source change together.
   // global gate, per-threshold selects.
   assign smi_gate = st.smi_sel[THR_N-1:0] & {THR_N{st.glob_smi}};
   assign smi_fire = (rise | fall) & smi_gate;

   //==============================================================
   // APB slave
   //==============================================================
   // Address decode and zero-wait handshake; unmapped places answer with an error.
   assign hit_status = reg_hit(paddr, STATUS_IDX);
   assign hit_sel    = reg_hit(paddr, SMI_SEL_IDX);
   assign hit_ist    = reg_hit(paddr, IRQ_ST_IDX);
   assign hit_msk    = reg_hit(paddr, IRQ_MSK_IDX);
   assign hit_ctrl   = reg_hit(paddr, CTRL_IDX);
   assign hit_any    = hit_status | hit_sel | hit_ist | hit_msk | hit_ctrl;
   assign wr_acc     = psel & penable & pwrite;
   assign rd_acc     = psel & penable & ~pwrite;
   assign pready     = psel & penable;
   assign pslverr    = psel & penable & ~hit_any;

   // Expands byte strobes into a bit mask.
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{pstrb[b]}};
      end
   end

   // Read value of the addressed register; unmapped reads return zero.
   always_comb begin
      rd_val = '0;
      if (hit_status) begin
         rd_val[15:0] = status;
      end else if (hit_sel) begin
         rd_val[7:0] = st.smi_sel;
      end else if (hit_ist) begin
         rd_val[15:0] = irq_stat;
      end else if (hit_msk) begin
         rd_val[15:0] = st.irq_mask;
      end else if (hit_ctrl) begin
         rd_val[CTRL_GSMI] = st.glob_smi;
      end
   end

   // Register writes, read capture and the SMI pulse.
   always_comb begin
      next_st = st;
      // Read data is taken in the setup cycle, so the access cycle shows a settled word
      // and a read-clear removes exactly the bits that software is given.
      if (psel && !penable) begin
         next_st.rdata = rd_val;
      end
      if (wr_acc && hit_sel) begin
         next_st.smi_sel = 8'(merge({8'h00, st.smi_sel}, pwdata[15:0], wmask[15:0])) & SMI_IMPL;
      end
      if (wr_acc && hit_msk) begin
         next_st.irq_mask = merge(st.irq_mask, pwdata[15:0], wmask[15:0]) & STATUS_IMPL;
      end
      if (wr_acc && hit_ctrl && pstrb[0]) begin
         next_st.glob_smi = pwdata[CTRL_GSMI];
      end
      next_st.smi_req = |smi_fire;
      next_st.smi_src = smi_fire;
   end

   // reset defaults of the select register and outputs.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st          <= '0;
         st.smi_sel  <= SMI_RST;
         st.irq_mask <= MASK_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the registered state.
   assign prdata     = st.rdata;
   assign smi_req    = st.smi_req;
   assign smi_source = st.smi_src;

   //==============================================================
   // Checks
   //==============================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Status bits that survive this cycle's clear.
   logic [15:0] held;
   assign held = status & ~status_clr;

   // Each trip edge lands in its own status bit one cycle later.
   AST_CAT_FALL: assert property ($fell(cat_trip) |=> status[FALL_POS[THR_CAT]])
      else $error("Catastrophic falling trip did not set its status bit.");
   AST_HOT_FALL: assert property ($fell(hot_trip) |=> status[FALL_POS[THR_HOT]])
      else $error("Hot falling trip did not set its status bit.");
   AST_AUX_FALL: assert property ($fell(aux_trip) |=> status[FALL_POS[THR_AUX]])
      else $error("Auxiliary falling trip did not set its status bit.");
   AST_CAT_RISE: assert property ($rose(cat_trip) |=> status[RISE_POS[THR_CAT]])
      else $error("Catastrophic rising trip did not set its status bit.");
   AST_HOT_RISE: assert property ($rose(hot_trip) |=> status[RISE_POS[THR_HOT]])
      else $error("Hot rising trip did not set its status bit.");
   AST_AUX_RISE: assert property ($rose(aux_trip) |=> status[RISE_POS[THR_AUX]])
      else $error("Auxiliary rising trip did not set its status bit.");

   //==============================================================
   // Status flag checks
   //==============================================================
   AST_STATUS_HOLD: assert property (held != '0 |=> (status & $past(held)) == $past(held))
      else $error("A status bit dropped without a written one.");
   AST_CLEAR_LANDS: assert property (status_clr != '0 |=> (status & $past(status_clr & ~status_set)) == '0)
      else $error("A written one did not clear its status bit.");
   AST_RESET_ZERO: assert property ($rose(rst_n) |-> status == STATUS_RST && st.smi_sel == SMI_RST)
      else $error("Status or SMI select not zero after reset.");

   //==============================================================
   // SMI message checks
   //==============================================================
   AST_SMI_CAT: assert property ((rise[THR_CAT] || fall[THR_CAT]) |=>
      smi_source[THR_CAT] == $past(smi_gate[THR_CAT]) && (smi_req || !$past(smi_gate[THR_CAT])))
      else $error("Catastrophic SMI gating wrong.");
   AST_SMI_HOT: assert property ((rise[THR_HOT] || fall[THR_HOT]) |=>
      smi_source[THR_HOT] == $past(smi_gate[THR_HOT]))
      else $error("Hot SMI gating wrong.");
   AST_SMI_AUX: assert property ((rise[THR_AUX] || fall[THR_AUX]) |=>
      smi_source[THR_AUX] == $past(smi_gate[THR_AUX]))
      else $error("Auxiliary SMI gating wrong.");
   AST_SMI_GLOBAL: assert property (!st.glob_smi |=> !smi_req)
      else $error("SMI message sent without global enable.");
   AST_SMI_NO_EVENT: assert property ((rise | fall) == '0 |=> !smi_req)
      else $error("SMI message sent without a trip edge.");
   // Writes to the select land in the next cycle with reserved bits dropped.
   AST_SEL_WRITE: assert property (wr_acc && hit_sel && pstrb[0] |=>
      st.smi_sel == ($past(pwdata[7:0]) & SMI_IMPL))
      else $error("SMI select write did not land.");

   //==============================================================
   // Register and cause checks
   //==============================================================
   AST_RSVD_ZERO: assert property ((status & ~STATUS_IMPL) == '0 && (st.smi_sel & ~SMI_IMPL) == '0)
      else $error("Reserved bit holds a one.");
   AST_IRQ_CAUSE: assert property (status_set != '0 |=> (irq_stat & $past(status_set)) == $past(status_set))
      else $error("Trip event not recorded for the interrupt.");
   AST_NO_SPURIOUS: assert property ((status & ~$past(status) & ~$past(status_set)) == '0)
      else $error("Status bit set without its trip edge.");
   AST_IRQ_READ_CLEAR: assert property (irq_clr != '0 |=> (irq_stat & $past(irq_clr & ~status_set)) == '0)
      else $error("Interrupt status read did not clear the returned bits.");
   // Reads of either documented register return zero in reserved places.
   AST_RSVD_READ: assert property (rd_acc && (hit_status || hit_sel) |->
      (prdata & ~(hit_sel ? 32'(SMI_IMPL) : 32'(STATUS_IMPL))) == '0)
      else $error("Reserved bits read as one.");
endmodule

// File: test/tte_smi_sink.sv
//==============================================================
// Link message sink
//==============================================================
module tte_smi_sink (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       smi_req,
   input  wire logic [2:0] smi_source,
   output logic            msg_seen,
   output logic      [2:0] msg_src
);
   timeunit 1ns;
   timeprecision 1ps;

   // Accepts each request as one message; between messages the source shows a changing pattern.
   // SMI reporting: this sink stands for the SMI message path; the interrupt goes out separately on irq.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         msg_seen <= 1'b0;
         msg_src  <= 3'h0;
      end else begin
         msg_seen <= smi_req;
         msg_src  <= smi_req ? smi_source : ~msg_src;
      end
   end
endmodule

// File: test/test_thermal_trip_event_status.sv
//==============================================================
// Thermal trip event status bench
//==============================================================
module test_thermal_trip_event_status;
   import tte_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic              sys_clk = 1'b0;
   logic              arst_n  = 1'b0;
   logic [ADDR_W-1:0] paddr   = '0;
   logic              psel    = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite  = 1'b0;
   logic [31:0]       pwdata  = '0;
   logic [3:0]        pstrb   = 4'h0;
   logic [3:0]        wstrb   = 4'hf;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [2:0]        trip    = 3'h0;
   logic              smi_req;
   logic [2:0]        smi_source;
   logic              irq;
   logic              msg_seen;
   logic [2:0]        msg_src;
   logic [32:0]       rd_q[$];
   logic [2:0]        smi_q[$];
   logic [2:0]        sel;
   logic [31:0]       seed    = 32'he626;
   int                miscompares = 0;
   int                checks      = 0;
   int                cyc         = 0;

   tte_thermal_trip_event_status dut_u (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .paddr      (paddr),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .pwdata     (pwdata),
      .pstrb      (pstrb),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .cat_trip   (trip[THR_CAT]),
      .hot_trip   (trip[THR_HOT]),
      .aux_trip   (trip[THR_AUX]),
      .smi_req    (smi_req),
      .smi_source (smi_source),
      .irq        (irq)
   );

   tte_smi_sink sink_u (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .smi_req    (smi_req),
      .smi_source (smi_source),
      .msg_seen   (msg_seen),
      .msg_src    (msg_src)
   );

   // Clock at 40 MHz.
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [ADDR_W-1:0] addr_of(input logic [11:0] idx);
      return ADDR_W'(idx) << IDX_SHIFT;
   endfunction

   // One APB transfer; a read notes its expected error flag and data first.
   task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
      @(posedge sys_clk);
      if (!w) rd_q.push_back(e);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      pstrb   <= wstrb;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Raises and drops each trip level, noting the message each edge should send.
   task automatic run_trips(input logic glob_on);
      for (int i = 0; i < THR_N; i++) begin
         for (int lv = 1; lv >= 0; lv--) begin
            @(posedge sys_clk);
            trip[i] <= lv[0];
            if (glob_on && sel[i]) smi_q.push_back(3'(1 << i));
            repeat (3) @(posedge sys_clk);
         end
      end
   endtask

   task automatic check_irq(input logic exp);
      @(posedge sys_clk);
      #1;
      check({32'h0, irq}, {32'h0, exp}); // irq level
   endtask

   // Read data monitor: compares each completed read with the oldest note.
   always @(posedge sys_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check({pslverr, prdata}, rd_q.pop_front()); // read data
      end
   end

   // Message monitor: every message must match a noted source.
   always @(posedge sys_clk) begin
      if (msg_seen === 1'b1) begin
         if (smi_q.size() == 0) check({30'h0, msg_src}, 33'h1ffffffff); // no message
         else check({30'h0, msg_src}, {30'h0, smi_q.pop_front()}); // source
      end
   end

   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         test_done();
      end
   end

   // Main sequence.
   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, 33'h0);
      apb(addr_of(SMI_SEL_IDX), 1'b0, 32'h0, 33'h0);
      apb(16'h0100, 1'b0, 32'h0, 33'h100000000);
      for (int k = 0; k < 4; k++) begin
         seed = xorshift(seed);
         apb(addr_of(SMI_SEL_IDX), 1'b1, seed, 33'h0);
         apb(addr_of(SMI_SEL_IDX), 1'b0, 32'h0, {25'h0, seed[7:0] & SMI_IMPL});
      end
      sel = 3'b101;
      apb(addr_of(SMI_SEL_IDX), 1'b1, {29'h0, sel}, 33'h0);
      apb(addr_of(CTRL_IDX), 1'b1, 32'h1 << CTRL_GSMI, 33'h0);
      apb(addr_of(CTRL_IDX), 1'b0, 32'h0, 33'h1 << CTRL_GSMI);
      run_trips(1'b1);
      sel = 3'b010;
      apb(addr_of(SMI_SEL_IDX), 1'b1, {29'h0, sel}, 33'h0);
      run_trips(1'b1);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, {17'h0, STATUS_IMPL});
      check_irq(1'b0);
      apb(addr_of(STATUS_IDX), 1'b1, 32'h0, 33'h0);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, 33'h0039c);
      apb(addr_of(STATUS_IDX), 1'b1, 32'h1 << RISE_POS[THR_CAT], 33'h0);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, 33'h0038c);
      // a disabled byte lane writes nothing
      wstrb = 4'he;
      apb(addr_of(STATUS_IDX), 1'b1, 32'hffff, 33'h0);
      wstrb = 4'hf;
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, 33'h0008c);
      apb(addr_of(STATUS_IDX), 1'b1, 32'hffff, 33'h0);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, 33'h0);
      apb(addr_of(IRQ_MSK_IDX), 1'b1, 32'h0000039c, 33'h0);
      apb(addr_of(IRQ_MSK_IDX), 1'b0, 32'h0, 33'h0039c);
      check_irq(1'b1);
      apb(addr_of(IRQ_ST_IDX), 1'b0, 32'h0, 33'h0039c);
      check_irq(1'b0);
      apb(addr_of(IRQ_ST_IDX), 1'b0, 32'h0, 33'h0);
      apb(addr_of(CTRL_IDX), 1'b1, 32'h0, 33'h0);
      run_trips(1'b0);
      check_irq(1'b1);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, {17'h0, STATUS_IMPL});
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      apb(addr_of(STATUS_IDX), 1'b0, 32'h0, 33'h0);
      apb(addr_of(SMI_SEL_IDX), 1'b0, 32'h0, 33'h0);
      check_irq(1'b0);
      repeat (4) @(posedge sys_clk);
      check({1'b0, 32'(smi_q.size())}, 33'h0); // all messages sent
      test_done();
   end
endmodule
